// File: aspab_pkg.sv
package aspab_pkg;

  // register byte offsets
  localparam logic [7:0] ASPAB_CTRL_OFF   = 8'h00;
  localparam logic [7:0] ASPAB_STAT_OFF   = 8'h04;
  localparam logic [7:0] ASPAB_CTRL2_OFF  = 8'h08;
  localparam logic [7:0] ASPAB_BAUDH_OFF  = 8'h0C;
  localparam logic [7:0] ASPAB_BAUDL_OFF  = 8'h10;
  localparam logic [7:0] ASPAB_TXDATA_OFF = 8'h14;
  localparam logic [7:0] ASPAB_RXDATA_OFF = 8'h18;
  localparam logic [7:0] ASPAB_PINSEL_OFF = 8'h1C;

  // control register fields
  localparam int CTRL_PORT_EN_BIT  = 7;
  localparam int CTRL_TX_EN_BIT    = 6;
  localparam int CTRL_TX9_BIT      = 5;
  localparam int CTRL_TX9D_BIT     = 4;
  localparam int CTRL_PARITY_BIT   = 3;
  localparam int CTRL_TXIE_BIT     = 1;
  localparam int CTRL_WAKE_BIT     = 0;

  // status register fields
  localparam int STAT_RX9D_BIT     = 6;
  localparam int STAT_PARITY_ERROR_FLAG_BIT     = 5;
  localparam int STAT_FRAMING_ERROR_FLAG_BIT     = 4;
  localparam int STAT_OVERRUN_FLAG_BIT     = 3;
  localparam int STAT_RXACT_BIT    = 2;
  localparam int STAT_SHEMPTY_BIT  = 1;
  localparam int STAT_ABROLL_BIT   = 0;
  localparam int STAT_TXEMPTY_BIT  = 8;
  localparam int STAT_TXBUSY_BIT   = 9;
  localparam int STAT_RXFLAG_BIT   = 10;

  // control register 2 fields
  localparam int CTRL2_ERRCLR_BIT  = 3;
  localparam int CTRL2_RX9_BIT     = 2;
  localparam int CTRL2_ABD_BIT     = 0;

  // pin select fields
  localparam int PINSEL_EN_BIT     = 3;

  localparam int          ASPAB_DIV_W      = 13;
  localparam int          ASPAB_PAIRS      = 8;
  localparam logic [12:0] ASPAB_ABD_LIMIT  = 13'h0FFF;
  localparam logic [7:0]  ASPAB_ABD_CHAR   = 8'h55;
  localparam int          ASPAB_TXE_DELAY  = 2;

  typedef enum logic [4:0] {
    ASPAB_TX_IDLE  = 5'b00001,
    ASPAB_TX_START = 5'b00010,
    ASPAB_TX_DATA  = 5'b00100,
    ASPAB_TX_STOP  = 5'b01000,
    ASPAB_TX_LOAD  = 5'b10000
  } aspab_tx_t;

  typedef enum logic [3:0] {
    ASPAB_RX_IDLE  = 4'b0001,
    ASPAB_RX_START = 4'b0010,
    ASPAB_RX_DATA  = 4'b0100,
    ASPAB_RX_STOP  = 4'b1000
  } aspab_rx_t;

endpackage : aspab_pkg

// File: aspab_uart.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
module aspab_uart
  import aspab_pkg::*;
#(
  parameter int          PAIRS     = ASPAB_PAIRS,
  parameter logic [12:0] ABD_LIMIT = ASPAB_ABD_LIMIT
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [PAIRS-1:0]  tx_pin_o,
  output logic      [PAIRS-1:0]  tx_pin_oe,
  input  wire logic [PAIRS-1:0]  rx_pin_i,
  output logic                   tx_irq
);

  logic [7:0]  ctrl_q;
  logic [2:0]  ctrl2_q;
  logic [4:0]  baud_hi_q;
  logic [7:0]  baud_lo_q;
  logic [3:0]  pinsel_q;
  logic        errclr_q;
  logic [8:0]  thr_q;
  logic        thr_full_q;
  logic [1:0]  txe_dly_q;
  logic        txe_flag_q;
  logic [8:0]  tsr_q;
  logic [3:0]  tx_cnt_q;
  logic        tx_line_q;
  aspab_tx_t   tx_st_q;
  aspab_rx_t   rx_st_q;
  logic [8:0]  rx_sh_q;
  logic [3:0]  rx_cnt_q;
  logic [8:0]  rx_fifo_q [2];
  logic [1:0]  rx_count_q;
  logic        rxflag_q, parity_error_flag_q, framing_error_flag_q, overrun_flag_q, abroll_q;
  logic [12:0] btick_q, rtick_q;
  logic [1:0]  rphase_q;
  logic        btick;
  logic        rx_line;
  logic        wr, rd;
  logic [12:0] divisor;
  logic [3:0]  nbits;
  logic [17:0] abd_cnt_q;
  logic [17:0] abd_rnd;
  logic [2:0]  abd_edges_q;
  logic        abd_busy_q;
  logic        abd_wait_q;
  logic        abd_prev_q;
  logic        abd_fall;
  logic        abd_clr;
  logic        rx_done;
  logic        rx_pop;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign divisor = {baud_hi_q, baud_lo_q};
  assign nbits   = ctrl_q[CTRL_TX9_BIT] ? 4'h9 : 4'h8;
  assign rx_line = pinsel_q[PINSEL_EN_BIT] ? rx_pin_i[pinsel_q[2:0]] : 1'b1;
  assign rx_pop  = rd && paddr == ASPAB_RXDATA_OFF;
  assign abd_rnd  = abd_cnt_q + 18'h00010;
  assign abd_fall = abd_prev_q && !rx_line;
  assign abd_clr  = abd_wait_q && rx_line && !abroll_q;

  //////////////////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped reads return zero with pslverr
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_q   <= 8'h00;
      ctrl2_q  <= 3'h0;
      pinsel_q <= 4'h0;
    end
    else
    begin
      if (wr && paddr == ASPAB_CTRL_OFF)
        ctrl_q <= pwdata[7:0];
      if (wr && paddr == ASPAB_PINSEL_OFF)
        pinsel_q <= pwdata[3:0];
      if (wr && paddr == ASPAB_CTRL2_OFF)
        ctrl2_q <= {pwdata[CTRL2_RX9_BIT], 1'b0, pwdata[CTRL2_ABD_BIT]};
      else if (abd_clr)
        ctrl2_q[CTRL2_ABD_BIT] <= 1'b0;
    end

  // error-clear is a one-cycle pulse; writing zero leaves it low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      errclr_q <= 1'b0;
    else
      errclr_q <= wr && paddr == ASPAB_CTRL2_OFF && pwdata[CTRL2_ERRCLR_BIT];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        unique case (paddr)
          ASPAB_CTRL_OFF:   prdata <= {24'h0, ctrl_q};
          ASPAB_STAT_OFF:   prdata <= {21'h0, rxflag_q, tx_st_q != ASPAB_TX_IDLE,
                                       txe_flag_q, 1'b0, rx_fifo_q[0][8], parity_error_flag_q, framing_error_flag_q,
                                       overrun_flag_q, rx_st_q != ASPAB_RX_IDLE,
                                       tx_st_q == ASPAB_TX_IDLE, abroll_q};
          ASPAB_CTRL2_OFF:  prdata <= {28'h0, 1'b0, ctrl2_q};
          ASPAB_BAUDH_OFF:  prdata <= {27'h0, baud_hi_q};
          ASPAB_BAUDL_OFF:  prdata <= {24'h0, baud_lo_q};
          ASPAB_TXDATA_OFF: prdata <= {24'h0, thr_q[7:0]};
          ASPAB_RXDATA_OFF: prdata <= {24'h0, rx_fifo_q[0][7:0]};
          ASPAB_PINSEL_OFF: prdata <= {28'h0, pinsel_q};
          default:          pslverr <= 1'b1;
        endcase
      end
    end

  //////////////////////////////////////////////////////////////////////////////////////////
  // baud generator: tick every 4*(n+1) cycles, shared by tx and rx
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      btick_q <= 13'h0000;
    else if (btick_q >= divisor)
      btick_q <= 13'h0000;
    else
      btick_q <= btick_q + 13'h0001;

  logic [1:0] quarter_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      quarter_q <= 2'h0;
    else if (btick_q >= divisor)
      quarter_q <= quarter_q + 2'h1;

  assign btick = btick_q >= divisor && quarter_q == 2'h3;

  // idle level after reset, so no false falling edge follows it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      abd_prev_q <= 1'b1;
    else
      abd_prev_q <= rx_line;

  // measurement and stored divisor
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      baud_hi_q   <= 5'h00;
      baud_lo_q   <= 8'h00;
      abd_cnt_q   <= 18'h00000;
      abd_edges_q <= 3'h0;
      abd_busy_q  <= 1'b0;
      abd_wait_q  <= 1'b0;
      abroll_q    <= 1'b0;
    end
    else
    begin
      if (wr && paddr == ASPAB_BAUDH_OFF)
        baud_hi_q <= pwdata[4:0];
      if (wr && paddr == ASPAB_BAUDL_OFF)
        baud_lo_q <= pwdata[7:0];
      if (wr && paddr == ASPAB_STAT_OFF && !pwdata[STAT_ABROLL_BIT])
        abroll_q <= 1'b0;
      if (!ctrl2_q[CTRL2_ABD_BIT])
      begin
        abd_busy_q  <= 1'b0;
        abd_wait_q  <= 1'b0;
        abd_edges_q <= 3'h0;
        abroll_q    <= 1'b0;
      end
      else if (abd_wait_q)
      begin
        // wait for the stop bit so the tail of the character is not taken as a frame
        if (rx_line)
          abd_wait_q <= 1'b0;
      end
      else if (!abd_busy_q)
      begin
        if (abd_fall)
        begin
          abd_busy_q  <= 1'b1;
          abd_cnt_q   <= 18'h00000;
          abd_edges_q <= 3'h0;
        end
      end
      else
      begin
        // 0x55 falls at start, d1, d3, d5 and d7: eight bit times in all
        if (!abd_cnt_q[17])
          abd_cnt_q <= abd_cnt_q + 18'h00001;
        if (abd_rnd[17:5] > ABD_LIMIT + 13'h0001)
          abroll_q <= 1'b1;
        if (abd_fall)
        begin
          abd_edges_q <= abd_edges_q + 3'h1;
          if (abd_edges_q == 3'h3)
          begin
            abd_busy_q <= 1'b0;
            abd_wait_q <= 1'b1;
            // 8 bit times = 32*(n+1) cycles, rounded to the nearest
            if (!abroll_q && abd_rnd[17:5] <= ABD_LIMIT + 13'h0001)
              {baud_hi_q, baud_lo_q} <= abd_rnd[17:5] - 13'h0001;
          end
        end
      end
    end

  //////////////////////////////////////////////////////////////////////////////////////////
  // transmitter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      thr_q      <= 9'h000;
      thr_full_q <= 1'b0;
      tsr_q      <= 9'h000;
      tx_cnt_q   <= 4'h0;
      tx_line_q  <= 1'b1;
      tx_st_q    <= ASPAB_TX_IDLE;
    end
    else
    begin
      if (wr && paddr == ASPAB_TXDATA_OFF)
      begin
        thr_q      <= {ctrl_q[CTRL_TX9D_BIT], pwdata[7:0]};
        thr_full_q <= 1'b1;
      end
      unique case (tx_st_q)
        ASPAB_TX_IDLE:
          if (thr_full_q && ctrl_q[CTRL_TX_EN_BIT] && ctrl_q[CTRL_PORT_EN_BIT])
            tx_st_q <= ASPAB_TX_LOAD;
        ASPAB_TX_LOAD:
        begin
          tsr_q      <= thr_q;
          thr_full_q <= wr && paddr == ASPAB_TXDATA_OFF;
          tx_st_q    <= ASPAB_TX_START;
        end
        ASPAB_TX_START:
          if (btick)
          begin
            tx_line_q <= 1'b0;
            tx_cnt_q  <= 4'h0;
            tx_st_q   <= ASPAB_TX_DATA;
          end
        ASPAB_TX_DATA:
          if (btick)
          begin
            tx_line_q <= tsr_q[0];
            tsr_q     <= {1'b0, tsr_q[8:1]};
            tx_cnt_q  <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == nbits - 4'h1)
              tx_st_q <= ASPAB_TX_STOP;
          end
        ASPAB_TX_STOP:
          if (btick)
          begin
            tx_line_q <= 1'b1;
            tx_st_q   <= ASPAB_TX_IDLE;
          end
        default:
          tx_st_q <= ASPAB_TX_IDLE;
      endcase
    end

  // tx-empty flag lags a write by two cycles; software cannot clear it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      txe_dly_q  <= 2'h0;
      txe_flag_q <= 1'b1;
    end
    else
    begin
      txe_dly_q <= {txe_dly_q[0], wr && paddr == ASPAB_TXDATA_OFF};
      if (txe_dly_q[ASPAB_TXE_DELAY-1] && thr_full_q)
        txe_flag_q <= 1'b0;
      else if (!thr_full_q && !txe_dly_q[0])
        txe_flag_q <= 1'b1;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_irq <= 1'b0;
    else
      tx_irq <= txe_flag_q && ctrl_q[CTRL_TXIE_BIT];

  // transmit pin routing
  for (genvar g = 0; g < PAIRS; g++)
  begin : g_pair
    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
        tx_pin_o[g]  <= 1'b1;
        tx_pin_oe[g] <= 1'b0;
      end
      else
      begin
        tx_pin_o[g]  <= tx_line_q;
        tx_pin_oe[g] <= pinsel_q[PINSEL_EN_BIT] && pinsel_q[2:0] == 3'(g);
      end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // receiver: samples at mid-bit using quarter-bit ticks of the same generator
  logic rq_tick;
  assign rq_tick = btick_q >= divisor;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_st_q  <= ASPAB_RX_IDLE;
      rx_sh_q  <= 9'h000;
      rx_cnt_q <= 4'h0;
      rphase_q <= 2'h0;
      rx_done  <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      unique case (rx_st_q)
        ASPAB_RX_IDLE:
          if (!rx_line && ctrl_q[CTRL_PORT_EN_BIT] && !ctrl_q[CTRL_WAKE_BIT]
              && !ctrl2_q[CTRL2_ABD_BIT])
          begin
            rphase_q <= 2'h0;
            rx_st_q  <= ASPAB_RX_START;
          end
        ASPAB_RX_START:
          if (rq_tick)
          begin
            rphase_q <= rphase_q + 2'h1;
            if (rphase_q == 2'h1)
            begin
              rphase_q <= 2'h0;
              rx_cnt_q <= 4'h0;
              rx_st_q  <= rx_line ? ASPAB_RX_IDLE : ASPAB_RX_DATA;
            end
          end
        ASPAB_RX_DATA:
          if (rq_tick)
          begin
            rphase_q <= rphase_q + 2'h1;
            if (rphase_q == 2'h3)
            begin
              rx_sh_q  <= ctrl2_q[CTRL2_RX9_BIT] ? {rx_line, rx_sh_q[8:1]}
                                                 : {1'b0, rx_line, rx_sh_q[7:1]};
              rx_cnt_q <= rx_cnt_q + 4'h1;
              if (rx_cnt_q == (ctrl2_q[CTRL2_RX9_BIT] ? 4'h8 : 4'h7))
                rx_st_q <= ASPAB_RX_STOP;
            end
          end
        ASPAB_RX_STOP:
          if (rq_tick)
          begin
            rphase_q <= rphase_q + 2'h1;
            if (rphase_q == 2'h3)
            begin
              rx_done <= 1'b1;
              rx_st_q <= ASPAB_RX_IDLE;
            end
          end
        default:
          rx_st_q <= ASPAB_RX_IDLE;
      endcase
    end

  // stop sample is the line at the end of the stop state
  logic stop_bad;
  assign stop_bad = rx_st_q == ASPAB_RX_STOP && rq_tick && rphase_q == 2'h3 && !rx_line;

  // two-deep receive store and error flags; set wins over clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_fifo_q[0] <= 9'h000;
      rx_fifo_q[1] <= 9'h000;
      rx_count_q   <= 2'h0;
      rxflag_q     <= 1'b0;
      parity_error_flag_q       <= 1'b0;
      framing_error_flag_q       <= 1'b0;
      overrun_flag_q       <= 1'b0;
    end
    else
    begin
      if (rx_pop && rx_count_q != 2'h0)
      begin
        rx_fifo_q[0] <= rx_fifo_q[1];
        rx_count_q   <= rx_count_q - 2'h1;
      end
      if (rx_pop)
        rxflag_q <= 1'b0;
      if (errclr_q)
      begin
        framing_error_flag_q <= 1'b0;
        overrun_flag_q <= 1'b0;
      end
      if (stop_bad)
        framing_error_flag_q <= 1'b1;
      if (rx_done)
      begin
        rxflag_q <= 1'b1;
        parity_error_flag_q   <= ^rx_sh_q[7:0] ^ (ctrl2_q[CTRL2_RX9_BIT] & rx_sh_q[8])
                    ^ ctrl_q[CTRL_PARITY_BIT];
        if (rx_count_q == 2'h2 && !rx_pop)
          overrun_flag_q <= 1'b1;
        else if (rx_count_q == 2'h0 || (rx_count_q == 2'h1 && rx_pop))
        begin
          rx_fifo_q[0] <= rx_sh_q;
          rx_count_q   <= rx_pop ? 2'h1 : rx_count_q + 2'h1;
        end
        else
        begin
          rx_fifo_q[1] <= rx_sh_q;
          rx_count_q   <= rx_pop ? 2'h2 : rx_count_q + 2'h1;
        end
      end
    end

  //////////////////////////////////////////////////////////////////////////////////////////
  rx_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done |=> rxflag_q) else $error("receive flag not set");
  frame_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    stop_bad |=> framing_error_flag_q) else $error("framing error missed");
  txe_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ASPAB_TXDATA_OFF |=> ##2 !txe_flag_q || !thr_full_q)
    else $error("tx empty not cleared");
  errclr_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    errclr_q |=> !errclr_q || $past(wr)) else $error("error clear stuck");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[CTRL_TXIE_BIT] |=> !tx_irq) else $error("irq not gated");
  pin_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pinsel_q[PINSEL_EN_BIT] |=> tx_pin_oe == '0) else $error("pin driven");
  tx_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_st_q == ASPAB_TX_START && btick |=> !tx_line_q) else $error("no start bit");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("pready late");
  tx_cov_c: cover property (@(posedge pclk) tx_st_q == ASPAB_TX_STOP && btick);
  rx_cov_c: cover property (@(posedge pclk) rx_done);
  ovr_cov_c: cover property (@(posedge pclk) rx_done && rx_count_q == 2'h2);

endmodule : aspab_uart

// File: aspab_remote.sv
`timescale 1ns/1ps
module aspab_remote (
  input  wire logic pclk,
  input  wire logic from_dev,
  output logic      to_dev
);
  initial to_dev = 1'b1;
  // a low stop_ok breaks the frame; one idle bit follows every frame
  task automatic send(input logic [8:0] d, input int nb, input logic stop_ok, input int bc);
    logic b;
    for (int i = 0; i < nb + 3; i++)
    begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? stop_ok : 1'b1;
      @(posedge pclk);
      to_dev <= b;
      repeat (bc - 1) @(posedge pclk);
    end
  endtask : send
  // samples mid-bit; ok falls on a bad start or stop bit, or when no frame came
  task automatic recv(input int nb, input int bc, output logic [8:0] d, output logic ok);
    int n;
    d = 9'h000;
    n = 0;
    while (from_dev !== 1'b0 && n < 4000)
    begin
      @(negedge pclk);
      n++;
    end
    repeat (bc / 2) @(negedge pclk);
    ok = from_dev === 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      repeat (bc) @(negedge pclk);
      d[i] = from_dev;
    end
    repeat (bc) @(negedge pclk);
    ok = ok && from_dev === 1'b1;
  endtask : recv
endmodule : aspab_remote

// File: aspab_uart_test.sv
`timescale 1ns/1ps
module aspab_uart_test;
  import aspab_pkg::*;
  localparam int BIT = 4 * (3 + 1);
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  tx_pin_o;
  logic [7:0]  tx_pin_oe;
  logic [7:0]  rx_pin_i;
  logic        tx_irq;
  logic        rmt_line;
  int          n_mismatch = 0;
  int          n_compared = 0;
  // pairs other than the one in use rest at the idle mark level
  always_comb
  begin
    rx_pin_i    = 8'hFF;
    rx_pin_i[6] = rmt_line;
  end
  // a low rollover limit keeps the rollover scenario short
  aspab_uart #(.PAIRS(8), .ABD_LIMIT(13'h0FF)) i_aspab_uart (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .tx_pin_o  (tx_pin_o),
    .tx_pin_oe (tx_pin_oe),
    .rx_pin_i  (rx_pin_i),
    .tx_irq    (tx_irq)
  );
  aspab_remote i_aspab_remote (
    .pclk     (pclk),
    .from_dev (tx_pin_o[6]),
    .to_dev   (rmt_line)
  );
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // answer taken at the rising edge where pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdv(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rdv
  ////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] v;
    logic        e;
    rdv(ASPAB_STAT_OFF, v);
    chk({v[STAT_SHEMPTY_BIT], v[STAT_TXBUSY_BIT], v[STAT_TXEMPTY_BIT]}, 3'b101, "reset");
    chk({tx_pin_o, tx_pin_oe}, 16'hFF00, "pins idle");
    apb(1'b0, 8'h40, 32'h0, v, e);
    chk({e, v[7:0]}, 9'h100, "unmapped");
    for (int c = 0; c < 8; c++)
    begin
      wr(ASPAB_PINSEL_OFF, 32'h8 | c);
      repeat (2) @(negedge pclk);
      chk(tx_pin_oe, 32'h1 << c, "pair");
    end
    wr(ASPAB_PINSEL_OFF, 32'h6);
    repeat (2) @(negedge pclk);
    chk(tx_pin_oe, 32'h0, "pair off");
    wr(ASPAB_PINSEL_OFF, 32'hE);
  endtask : t_reset
  task automatic t_tx(input logic nine);
    logic [31:0] v;
    logic [8:0]  g0, g1;
    logic        k0, k1;
    wr(ASPAB_CTRL_OFF, {26'h0, nine, nine, 4'h2} | 32'hC0);
    repeat (2) @(negedge pclk);
    chk(tx_irq, 1'b1, "irq empty");
    fork
      begin
        i_aspab_remote.recv(8 + nine, BIT, g0, k0);
        i_aspab_remote.recv(8 + nine, BIT, g1, k1);
      end
      begin
        wr(ASPAB_TXDATA_OFF, 32'hA5);
        repeat (4) @(negedge pclk);
        rdv(ASPAB_STAT_OFF, v);
        chk({v[STAT_SHEMPTY_BIT], v[STAT_TXBUSY_BIT]}, 2'b01, "tx busy");
        wr(ASPAB_TXDATA_OFF, 32'h3C);
        repeat (2) @(negedge pclk);
        rdv(ASPAB_STAT_OFF, v);
        chk(v[STAT_TXEMPTY_BIT], 1'b0, "holding full");
        chk(tx_irq, 1'b0, "irq full");
      end
    join
    chk({k0, g0, k1, g1}, {1'b1, nine, 8'hA5, 1'b1, nine, 8'h3C}, "tx line");
    repeat (BIT) @(negedge pclk);
    rdv(ASPAB_STAT_OFF, v);
    chk({v[STAT_SHEMPTY_BIT], v[STAT_TXBUSY_BIT], v[STAT_TXEMPTY_BIT]}, 3'b101, "tx done");
  endtask : t_tx
  task automatic t_rx;
    logic [31:0] v;
    fork
      i_aspab_remote.send(9'h03D, 8, 1'b1, BIT);
      begin
        repeat (3 * BIT) @(negedge pclk);
        rdv(ASPAB_STAT_OFF, v);
        chk(v[STAT_RXACT_BIT], 1'b1, "rx active");
      end
    join
    wr(ASPAB_STAT_OFF, 32'h0);
    rdv(ASPAB_STAT_OFF, v);
    chk({v[STAT_RXFLAG_BIT], v[STAT_PARITY_ERROR_FLAG_BIT], v[STAT_RXACT_BIT]},
        {1'b1, ^8'h3D, 1'b0}, "rx status");
    rdv(ASPAB_RXDATA_OFF, v);
    chk(v, 32'h3D, "rx data");
    rdv(ASPAB_STAT_OFF, v);
    chk(v[STAT_RXFLAG_BIT], 1'b0, "flag popped");
    wr(ASPAB_CTRL2_OFF, 32'h4);
    wr(ASPAB_CTRL_OFF, 32'hC8);
    i_aspab_remote.send(9'h13C, 9, 1'b1, BIT);
    rdv(ASPAB_STAT_OFF, v);
    chk({v[STAT_RX9D_BIT], v[STAT_PARITY_ERROR_FLAG_BIT]}, {1'b1, ^9'h13C ^ 1'b1}, "rx 9");
    rdv(ASPAB_RXDATA_OFF, v);
    chk(v[7:0], 8'h3C, "rx data 9");
    wr(ASPAB_CTRL2_OFF, 32'h0);
    wr(ASPAB_CTRL_OFF, 32'hC0);
  endtask : t_rx
  task automatic t_err;
    logic [31:0] v;
    i_aspab_remote.send(9'h0F0, 8, 1'b0, BIT);
    // a low stop may be taken as a fresh start bit, so let that settle
    repeat (12 * BIT) @(negedge pclk);
    wr(ASPAB_CTRL2_OFF, 32'h0);
    rdv(ASPAB_STAT_OFF, v);
    chk(v[STAT_FRAMING_ERROR_FLAG_BIT], 1'b1, "framing_error_flag");
    wr(ASPAB_CTRL2_OFF, 32'h8);
    rdv(ASPAB_CTRL2_OFF, v);
    chk(v[CTRL2_ERRCLR_BIT], 1'b0, "clear bit");
    rdv(ASPAB_STAT_OFF, v);
    chk(v[STAT_FRAMING_ERROR_FLAG_BIT], 1'b0, "framing_error_flag clear");
    rdv(ASPAB_RXDATA_OFF, v);
    rdv(ASPAB_RXDATA_OFF, v);
    for (int i = 1; i < 4; i++)
      i_aspab_remote.send(9'(i * 17), 8, 1'b1, BIT);
    rdv(ASPAB_STAT_OFF, v);
    chk(v[STAT_OVERRUN_FLAG_BIT], 1'b1, "overrun");
    rdv(ASPAB_RXDATA_OFF, v);
    chk(v, 32'h11, "first kept");
    rdv(ASPAB_RXDATA_OFF, v);
    chk(v, 32'h22, "second kept");
    wr(ASPAB_CTRL2_OFF, 32'h8);
    rdv(ASPAB_STAT_OFF, v);
    chk({v[STAT_OVERRUN_FLAG_BIT], v[STAT_RXFLAG_BIT]}, 2'b00, "overrun clear");
  endtask : t_err
  task automatic t_abd;
    logic [31:0] v;
    logic [31:0] h;
    wr(ASPAB_BAUDL_OFF, 32'h0);
    wr(ASPAB_CTRL2_OFF, 32'h1);
    i_aspab_remote.send(9'h055, 8, 1'b1, 24);
    rdv(ASPAB_CTRL2_OFF, v);
    chk(v[CTRL2_ABD_BIT], 1'b0, "abd done");
    rdv(ASPAB_BAUDL_OFF, v);
    rdv(ASPAB_BAUDH_OFF, h);
    chk(v >= 32'h4 && v <= 32'h6 && h == 32'h0, 1'b1, "divisor");
    wr(ASPAB_BAUDL_OFF, 32'h0);
    rdv(ASPAB_RXDATA_OFF, v);
    wr(ASPAB_CTRL2_OFF, 32'h1);
    i_aspab_remote.send(9'h055, 8, 1'b1, 1100);
    rdv(ASPAB_STAT_OFF, v);
    rdv(ASPAB_CTRL2_OFF, h);
    chk({v[STAT_ABROLL_BIT], h[CTRL2_ABD_BIT]}, 2'b11, "rollover");
    wr(ASPAB_CTRL2_OFF, 32'h0);
    rdv(ASPAB_STAT_OFF, v);
    chk(v[STAT_ABROLL_BIT], 1'b0, "rollover clear");
  endtask : t_abd
  ////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    wr(ASPAB_BAUDL_OFF, 32'h3);
    t_tx(1'b0);
    t_tx(1'b1);
    t_rx();
    t_err();
    t_abd();
    give_verdict();
  end
endmodule : aspab_uart_test
